// file: src/etas_map.vh
// register map, field positions and timing constants of the acquisition sequencer
`ifndef ETAS_MAP_VH
`define ETAS_MAP_VH
// -----------------------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------------------
`define ETAS_REG_CTRL      12'h000
`define ETAS_REG_STATUS    12'h004
`define ETAS_REG_ACQ_DLY   12'h008
`define ETAS_REG_INTEG     12'h00c
`define ETAS_REG_SS_DLY    12'h010
`define ETAS_REG_SS_WIDTH  12'h014
`define ETAS_REG_CS_PER    12'h018
`define ETAS_REG_VARIANT   12'h01c
// -----------------------------------------------------------------------------
// fields
// -----------------------------------------------------------------------------
`define ETAS_CTRL_MODE_LO  0
`define ETAS_CTRL_MODE_HI  1
`define ETAS_CTRL_SWTRIG   2
`define ETAS_CTRL_XFER_ACK 3
`define ETAS_MODE_SW       2'h0
`define ETAS_MODE_EDGE     2'h1
`define ETAS_MODE_LEVEL    2'h2
`define ETAS_VAR_FAST      1'h0
`define ETAS_VAR_SLOW      1'h1
// -----------------------------------------------------------------------------
// reset values and timing, in microseconds unless named otherwise
// -----------------------------------------------------------------------------
`define ETAS_ACQ_DLY_MAX_US   32'd335500
`define ETAS_INTEG_RST_US     32'd3800
`define ETAS_SLOW_BUSY_US     32'd3706
`define ETAS_SLOW_INTEG_MIN   32'd3800
`define ETAS_SLOW_INTEG_MAX   32'd10000000
`define ETAS_FAST_BUSY1_MIN   32'd1
`define ETAS_FAST_BUSY1_KNEE  32'd218
`define ETAS_FAST_BUSY1_BASE  32'd219
`define ETAS_FAST_BUSY2_US    32'd218
`define ETAS_CLK_MHZ          125
`define ETAS_TRIG_DLY_MIN_NS  20
`define ETAS_TRIG_DLY_MAX_NS  30
`define ETAS_CLK_NS           8
`endif

// file: src/etas_sequencer.v
// edge-trigger acquisition sequencer with apb register slave
// Function
// - in edge mode a rising trigger input edge starts an acquisition cycle
// - trigger event registered 20 to 30 ns after the input rise
// - phases run busy1 plus acquisition delay, integration, then busy2
// - acquisition delay 0 to 335500 us, 1 us steps, delays only integration
// - single strobe delay counts from the trigger event
// - single strobe high for programmed width, forced low by integration end
// - continuous strobe first period starts exactly with integration
// - only complete continuous strobe periods, otherwise output held low
// - idle tail after last period is between zero and one period
// - continuous strobe deasserted when integration ends
// - slow variant: 3706 us busy times, integration 3800 us to 10 s
// - fast variant: busy1 1 us or 219 minus integration; busy2 218 us
// - software, edge and level modes selectable, but level mode starts no cycle; software is default
// - each continuous strobe period high for half rounded up, low for half rounded down
// - after busy2 data transfer, then ready for next trigger
`timescale 1ns/1ps
`default_nettype none
`include "etas_map.vh"
module etas_sequencer #(
  parameter integer CLK_MHZ = `ETAS_CLK_MHZ // clock rate in MHz
) (
  input  wire        pclk,         // apb clock, 125 MHz
  input  wire        presetn,      // async reset, active low
  input  wire        psel,         // apb select
  input  wire        penable,      // apb enable
  input  wire        pwrite,       // apb direction
  input  wire [11:0] paddr,        // apb byte address
  input  wire [31:0] pwdata,       // apb write data
  output reg  [31:0] prdata,       // apb read data
  output reg         pready,       // apb ready
  output reg         pslverr,      // apb error on unmapped address
  input  wire        ext_trigger,  // external trigger pin
  output reg         single_strobe,// single strobe pin
  output reg         cont_strobe,  // continuous strobe pin
  output reg         acq_busy,     // acquisition cycle running
  output reg         xfer_req      // data ready for host transfer
);
  // ---------------------------------------------------------------------------
  // timing constants
  // ---------------------------------------------------------------------------
  localparam integer TRIG_DLY_MIN_NS = `ETAS_TRIG_DLY_MIN_NS;
  localparam integer TRIG_DLY_MAX_NS = `ETAS_TRIG_DLY_MAX_NS;
  // two sync stages plus edge register: 3 cycles = 24 ns, inside the window
  localparam integer TRIG_DLY_CYC = (TRIG_DLY_MIN_NS + `ETAS_CLK_NS - 1) / `ETAS_CLK_NS;

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_INTEG = 3'h2;
  localparam [2:0] ST_BUSY2 = 3'h3;
  localparam [2:0] ST_XFER  = 3'h4;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  reg  [1:0]  mode;
  reg         variant;
  reg  [31:0] acq_dly;
  reg  [31:0] integ;
  reg  [31:0] ss_dly;
  reg  [31:0] ss_width;
  reg  [31:0] cs_per;
  reg         sw_trig;
  reg         xfer_ack;
  reg         trig_seen;
  reg  [2:0]  state;
  reg  [31:0] phase_cnt;
  reg  [31:0] ss_cnt;
  reg  [31:0] cs_cnt;
  reg  [31:0] integ_left;
  reg         trig_s1;
  reg         trig_s2;
  reg         trig_prev;
  reg  [31:0] ssw_cnt;
  wire        ss_expired;
  wire        us_tick;
  wire        trig_event;
  wire        wr_en;
  wire        rd_en;
  wire        phase_done;
  wire        cs_start;

  function [31:0] clamp_integ;
    input [31:0] val;
    input        slow;
    begin
      if (slow && val < `ETAS_SLOW_INTEG_MIN)
        clamp_integ = `ETAS_SLOW_INTEG_MIN;
      else if (slow && val > `ETAS_SLOW_INTEG_MAX)
        clamp_integ = `ETAS_SLOW_INTEG_MAX;
      else if (val == 32'h0)
        clamp_integ = 32'h1;
      else
        clamp_integ = val;
    end
  endfunction

  function [31:0] busy1_us;
    input [31:0] it;
    input        slow;
    begin
      if (slow)
        busy1_us = `ETAS_SLOW_BUSY_US;
      else if (it >= `ETAS_FAST_BUSY1_KNEE)
        busy1_us = `ETAS_FAST_BUSY1_MIN;
      else
        busy1_us = `ETAS_FAST_BUSY1_BASE - it;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode     <= `ETAS_MODE_SW;
      variant  <= `ETAS_VAR_FAST;
      acq_dly  <= 32'h0;
      integ    <= `ETAS_INTEG_RST_US;
      ss_dly   <= 32'h0;
      ss_width <= 32'h0;
      cs_per   <= 32'h0;
      sw_trig  <= 1'b0;
      xfer_ack <= 1'b0;
    end else begin
      sw_trig  <= 1'b0;
      xfer_ack <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `ETAS_REG_CTRL: begin
            mode     <= pwdata[`ETAS_CTRL_MODE_HI:`ETAS_CTRL_MODE_LO];
            sw_trig  <= pwdata[`ETAS_CTRL_SWTRIG];
            xfer_ack <= pwdata[`ETAS_CTRL_XFER_ACK];
          end
          `ETAS_REG_ACQ_DLY: begin
            // saturate at the longest delay the sequencer supports
            if (pwdata > `ETAS_ACQ_DLY_MAX_US)
              acq_dly <= `ETAS_ACQ_DLY_MAX_US;
            else
              acq_dly <= pwdata;
          end
          `ETAS_REG_INTEG:    integ    <= pwdata;
          `ETAS_REG_SS_DLY:   ss_dly   <= pwdata;
          `ETAS_REG_SS_WIDTH: ss_width <= pwdata;
          `ETAS_REG_CS_PER:   cs_per   <= pwdata;
          `ETAS_REG_VARIANT:  variant  <= pwdata[0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `ETAS_REG_CTRL:     prdata <= {30'h0, mode};
          `ETAS_REG_STATUS:   prdata <= {27'h0, xfer_req, trig_seen, state};
          `ETAS_REG_ACQ_DLY:  prdata <= acq_dly;
          `ETAS_REG_INTEG:    prdata <= integ;
          `ETAS_REG_SS_DLY:   prdata <= ss_dly;
          `ETAS_REG_SS_WIDTH: prdata <= ss_width;
          `ETAS_REG_CS_PER:   prdata <= cs_per;
          `ETAS_REG_VARIANT:  prdata <= {31'h0, variant};
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
        if (!rd_en)
          prdata <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // trigger input
  // ---------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1   <= 1'b0;
      trig_s2   <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_s1   <= ext_trigger;
      trig_s2   <= trig_s1;
      trig_prev <= trig_s2;
    end
  end

  // a 10 ns pulse spans at least one edge of the 8 ns clock
  assign trig_event = (state == ST_IDLE) &&
                      (((mode == `ETAS_MODE_EDGE) && trig_s2 && !trig_prev) ||
                       ((mode == `ETAS_MODE_SW) && sw_trig));

  etas_us_tick #(
    .DIV (CLK_MHZ)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (trig_event),
    .tick    (us_tick)
  );

  // ---------------------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------------------
  assign phase_done = us_tick && (phase_cnt <= 32'h1);
  // a new strobe period starts only if it fits in the remaining integration
  // first period needs integration strictly longer than one period
  assign cs_start   = (cs_per != 32'h0) && (integ_left > cs_per);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      phase_cnt  <= 32'h0;
      integ_left <= 32'h0;
      ss_cnt     <= 32'h0;
      cs_cnt     <= 32'h0;
      acq_busy   <= 1'b0;
      xfer_req   <= 1'b0;
      trig_seen  <= 1'b0;
      single_strobe <= 1'b0;
      cont_strobe   <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          single_strobe <= 1'b0;
          cont_strobe   <= 1'b0;
          if (trig_event) begin
            state     <= ST_DELAY;
            acq_busy  <= 1'b1;
            trig_seen <= 1'b1;
            phase_cnt <= busy1_us(clamp_integ(integ, variant), variant) + acq_dly;
            ss_cnt    <= ss_dly;
            integ_left <= clamp_integ(integ, variant);
          end
        end
        ST_DELAY: begin
          if (phase_done) begin
            state     <= ST_INTEG;
            phase_cnt <= integ_left;
            if (cs_start) begin
              cont_strobe <= 1'b1;
              cs_cnt      <= cs_per;
            end
          end
        end
        ST_INTEG: begin
          if (us_tick) begin
            integ_left <= integ_left - 32'h1;
            phase_cnt  <= phase_cnt - 32'h1;
            if (cs_cnt == 32'h1) begin
              // period boundary: start the next only when it can complete
              cs_cnt      <= (integ_left - 32'h1 >= cs_per) ? cs_per : 32'h0;
              cont_strobe <= (integ_left - 32'h1 >= cs_per);
            end else if (cs_cnt != 32'h0) begin
              cs_cnt      <= cs_cnt - 32'h1;
              cont_strobe <= (cs_cnt - 32'h1 > (cs_per >> 1));
            end
          end
          if (phase_done) begin
            state         <= ST_BUSY2;
            phase_cnt     <= variant ? `ETAS_SLOW_BUSY_US : `ETAS_FAST_BUSY2_US;
            cont_strobe   <= 1'b0;
            single_strobe <= 1'b0;
          end
        end
        ST_BUSY2: begin
          if (phase_done)
            state <= ST_XFER;
        end
        ST_XFER: begin
          xfer_req <= 1'b1;
          if (xfer_req && xfer_ack) begin
            xfer_req <= 1'b0;
            acq_busy <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase

      if (state == ST_DELAY && us_tick && !phase_done)
        phase_cnt <= phase_cnt - 32'h1;
      if (state == ST_BUSY2 && us_tick && !phase_done)
        phase_cnt <= phase_cnt - 32'h1;

      // single strobe runs from the trigger event until integration ends
      if ((state == ST_DELAY || state == ST_INTEG) && us_tick && !(state == ST_INTEG && phase_done)) begin
        if (ss_cnt != 32'h0) begin
          ss_cnt <= ss_cnt - 32'h1;
          if (ss_cnt == 32'h1 && ss_width != 32'h0) begin
            single_strobe <= 1'b1;
            ss_cnt        <= 32'h0;
          end
        end
      end
      if (ss_expired)
        single_strobe <= 1'b0;
      if (state == ST_IDLE && trig_event && ss_dly == 32'h0 && ss_width != 32'h0)
        single_strobe <= 1'b1;
      if (wr_en && paddr == `ETAS_REG_STATUS)
        trig_seen <= trig_event;
    end
  end

  // single strobe width counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ssw_cnt <= 32'h0;
    else if (!single_strobe)
      ssw_cnt <= ss_width;
    else if (us_tick && ssw_cnt != 32'h0)
      ssw_cnt <= ssw_cnt - 32'h1;
  end
  // width expiry drops the pulse at the same tick that ends the width
  assign ss_expired = single_strobe && us_tick && (ssw_cnt == 32'h1);
endmodule
`default_nettype wire

// file: src/etas_us_tick.v
// microsecond tick divider for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module etas_us_tick #(
  parameter integer DIV = 125      // clock cycles per microsecond
) (
  input  wire pclk,                // system clock
  input  wire presetn,             // async reset, active low
  input  wire restart,             // realign divider phase
  output reg  tick                 // one-cycle pulse each microsecond
);
  reg [7:0] count;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (count == DIV[7:0] - 8'h01) begin
      count <= 8'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verif/edge_trigger_acquisition_sequencer_bench.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
`include "etas_map.vh"
module edge_trigger_acquisition_sequencer_bench;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        fire = 1'h0, pb = 1'h0, ps = 1'h0, pc = 1'h0, px = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, ext_trigger, ss, cs, busy, xr, er;
  integer      bad_count = 0, check_count = 0, cyc = 0, nb = 0, nc = 0, k;
  integer      tb, tsr, tsf, tc0, tcr, tcl, tx, hl;
  etas_sequencer #(.CLK_MHZ(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trigger(ext_trigger), .single_strobe(ss),
    .cont_strobe(cs), .acq_busy(busy), .xfer_req(xr));
  etas_trig_src u_src (.pclk(pclk), .presetn(presetn), .fire(fire), .hold_cycles(8'h2),
    .ext_trigger(ext_trigger));
  initial begin
    forever #4 pclk = ~pclk;
  end
  // --------------------------------------------------------
  // edge time stamps, in cycles
  // --------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    pb <= busy; ps <= ss; pc <= cs; px <= xr;
    if (busy && !pb) begin nb <= nb + 1; tb <= cyc; end
    if (ss && !ps) tsr <= cyc;
    if (!ss && ps) tsf <= cyc;
    if (cs && !pc) begin nc <= nc + 1; tcr <= cyc; if (nc == 0) tc0 <= cyc; end
    if (!cs && pc) begin tcl <= cyc; hl <= cyc - tcr; end
    if (xr && !px) tx <= cyc;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // tick phase makes edges land within one microsecond
  task near(input integer seen, input integer exp);
    chk({31'h0, seen >= exp - 8 && seen <= exp + 8}, 32'h1);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin bad_count++; end_of_test; end
    rd = prdata; er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task cfg(input logic [31:0] ad, it, sd, sw, cp);
    apb(1'h1, `ETAS_REG_VARIANT, {31'h0, `ETAS_VAR_FAST});
    apb(1'h1, `ETAS_REG_ACQ_DLY, ad); apb(1'h1, `ETAS_REG_INTEG, it);
    apb(1'h1, `ETAS_REG_SS_DLY, sd); apb(1'h1, `ETAS_REG_SS_WIDTH, sw);
    apb(1'h1, `ETAS_REG_CS_PER, cp);
    nb = 0; nc = 0;
  endtask
  task trig;
    @(posedge pclk);
    fire <= 1'h1;
    @(posedge pclk);
    fire <= 1'h0;
    k = 0;
    do begin @(posedge pclk); #1; k++; end while (busy !== 1'h1 && k < 6);
  endtask
  task fin(input logic [31:0] ctl);
    k = 0;
    while (xr !== 1'h1 && k < 20000) begin @(posedge pclk); k++; end
    if (k >= 20000) begin bad_count++; end_of_test; end
    apb(1'h1, `ETAS_REG_CTRL, ctl | 32'h8);
    apb(1'h0, `ETAS_REG_STATUS, 32'h0);
    chk(rd & 32'h10, 32'h0);
    chk({31'h0, busy}, 32'h0);
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `ETAS_REG_CTRL, 32'h0); chk(rd & 32'h3, {30'h0, `ETAS_MODE_SW});
    apb(1'h0, `ETAS_REG_INTEG, 32'h0); chk(rd, `ETAS_INTEG_RST_US);
    apb(1'h1, `ETAS_REG_ACQ_DLY, 32'd400000);
    apb(1'h0, `ETAS_REG_ACQ_DLY, 32'h0); chk(rd, 32'd335500);
    apb(1'h0, 12'h020, 32'h0); chk(rd, 32'h0); chk({31'h0, er}, 32'h1);
    $display("test reset done");
    // busy1 is 219 - 40 us; three 12 us periods fit in 40 us
    cfg(32'd10, 32'd40, 32'd5, 32'd3, 32'd12);
    apb(1'h1, `ETAS_REG_CTRL, {30'h0, `ETAS_MODE_EDGE});
    trig; chk({31'h0, k * 8 >= 20 && k * 8 <= 30}, 32'h1);
    repeat (100) @(posedge pclk);
    trig;
    fin({30'h0, `ETAS_MODE_EDGE});
    chk(nb, 32'h1);
    near(tc0 - tb, 189 * 8);
    near(tsr - tb, 5 * 8);
    near(tsf - tsr, 3 * 8);
    chk(nc, 32'h3);
    near(tcl - tc0, 30 * 8);
    near(hl, 6 * 8);
    near(tx - tc0, 258 * 8);
    $display("test edge done");
    // no acquisition delay, strobe cut by integration end, period too long
    cfg(32'd0, 32'd40, 32'd200, 32'd100, 32'd40);
    trig;
    fin({30'h0, `ETAS_MODE_EDGE});
    near(tsf - tb, 219 * 8);
    chk(nc, 32'h0);
    near(tx - tb, 437 * 8);
    $display("test cut strobe done");
    cfg(32'd0, 32'd250, 32'd0, 32'd0, 32'd100);
    apb(1'h1, `ETAS_REG_CTRL, {30'h0, `ETAS_MODE_SW});
    trig; chk({31'h0, busy}, 32'h0);
    apb(1'h1, `ETAS_REG_CTRL, 32'h4);
    fin(32'h0);
    chk(nb, 32'h1);
    near(tc0 - tb, 8);
    chk(nc, 32'h2);
    near(tx - tc0, 468 * 8);
    $display("test software done");
    end_of_test;
  end
endmodule
bind etas_sequencer etas_sequencer_checker #(.CLK_MHZ(CLK_MHZ)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_trigger(ext_trigger), .single_strobe(single_strobe), .cont_strobe(cont_strobe),
  .acq_busy(acq_busy), .xfer_req(xfer_req));
`default_nettype wire

// file: verif/etas_sequencer_assertions.sv
// port-level checks of the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module etas_sequencer_checker #(
  parameter integer CLK_MHZ = 125 // clock rate in MHz
) (
  input wire logic        pclk,          // clock
  input wire logic        presetn,       // reset, active low
  input wire logic        psel,          // apb select
  input wire logic        penable,       // apb enable
  input wire logic        pwrite,        // apb direction
  input wire logic [11:0] paddr,         // apb address
  input wire logic [31:0] pwdata,        // apb write data
  input wire logic [31:0] prdata,        // apb read data
  input wire logic        pready,        // apb ready
  input wire logic        pslverr,       // apb error
  input wire logic        ext_trigger,   // trigger pin
  input wire logic        single_strobe, // single strobe
  input wire logic        cont_strobe,   // continuous strobe
  input wire logic        acq_busy,      // cycle running
  input wire logic        xfer_req       // transfer pending
);
  logic [1:0] mode_q;
  // --------------------------------------------------------
  // trigger mode as last written
  // --------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
      mode_q <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_idle_edge;
    $rose(ext_trigger) && !acq_busy;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_edge_starts: assert property (s_idle_edge ##0 mode_q == 2'h1 |-> ##[2:3] acq_busy)
    else $error("edge did not start a cycle in time");
  a_pin_ignored_sw: assert property (s_idle_edge ##0 mode_q == 2'h0 |-> ##3 !acq_busy)
    else $error("pin started a cycle in software mode");
  a_strobe_in_cycle: assert property (single_strobe || cont_strobe |-> acq_busy)
    else $error("strobe outside a cycle");
  a_quiet_in_xfer: assert property (xfer_req |-> !single_strobe && !cont_strobe)
    else $error("strobe after integration");
  a_xfer_in_busy: assert property (xfer_req |-> acq_busy)
    else $error("busy dropped before transfer ack");
  a_busy_start: assert property ($rose(acq_busy) |-> !xfer_req && !cont_strobe)
    else $error("cycle started unclean");
  a_half_high: assert property ($rose(cont_strobe) |-> cont_strobe[*4])
    else $error("strobe high phase too short");
endmodule
`default_nettype wire

// file: verif/etas_trig_src.sv
// external trigger source model driving the trigger pin
`timescale 1ns/1ps
`default_nettype none
module etas_trig_src (
  input  wire logic       pclk,        // clock
  input  wire logic       presetn,     // reset, active low
  input  wire logic       fire,        // request one pulse
  input  wire logic [7:0] hold_cycles, // high time in cycles
  output var  logic       ext_trigger  // trigger pin
);
  logic [7:0] left;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_trigger <= 1'h0;
      left        <= 8'h0;
    end else if (fire && !ext_trigger) begin
      ext_trigger <= 1'h1;
      // never shorter than 16 ns high
      left        <= (hold_cycles < 8'h2) ? 8'h1 : hold_cycles - 8'h1;
    end else if (left != 8'h0) begin
      left <= left - 8'h1;
    end else begin
      ext_trigger <= 1'h0;
    end
  end
endmodule
`default_nettype wire
